// *** logic/ptcd_defs.svh ***
// ptcd_defs.svh - offsets, bit positions, reset values and bus answers
// of the current and parent dataset register bank.
// assumes byte addresses on a 16-bit register window, 32-bit words.
`ifndef PTCD_DEFS_SVH
`define PTCD_DEFS_SVH

// current dataset register offsets
`define PTCD_OFS_CUR_CTRL 16'h1300
`define PTCD_OFS_HOP_COUNT 16'h1304
`define PTCD_OFS_ERR_HIGH 16'h1308
`define PTCD_OFS_ERR_LOW 16'h130c
`define PTCD_OFS_LAT_HIGH 16'h1310
`define PTCD_OFS_LAT_LOW 16'h1314

// parent dataset register offsets
`define PTCD_OFS_PAR_CTRL 16'h1400
`define PTCD_OFS_UP_ID_LOW 16'h1404
`define PTCD_OFS_UP_ID_HIGH 16'h1408
`define PTCD_OFS_PRIO_PORT 16'h140c
`define PTCD_OFS_ROOT_ID_LOW 16'h1410
`define PTCD_OFS_ROOT_ID_HIGH 16'h1414

// control register fields
`define PTCD_BIT_DONE 31
`define PTCD_BIT_REQ 30
`define PTCD_REQ_LANE 3

// reset values
`define PTCD_RESET_WORD 32'h0000_0000
`define PTCD_RESET_HALF 16'h0000
`define PTCD_RESET_BYTE 8'h00
`define PTCD_RESET_DWORD 64'h0000_0000_0000_0000

// bus answers
`define PTCD_RESP_OKAY 2'h0
`define PTCD_RESP_DECERR 2'h3

`endif

// *** logic/ptcd_pkg.sv ***
// ptcd_pkg - shared types of the dataset register bank.
// assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package ptcd_pkg;
    typedef logic [31:0] ptcd_word_t;
    typedef logic [15:0] ptcd_half_t;
    typedef logic [7:0] ptcd_byte_t;
    // 64-bit value: scaled ns figure or 8-byte identity, byte 0 at [7:0]
    typedef logic [63:0] ptcd_dword_t;
    typedef logic [1:0] ptcd_resp_t;
endpackage

`default_nettype wire

// *** logic/ptcd_regbus_if.sv ***
// ptcd_regbus_if - internal register access port between the bus
// front end and the register bank; one access per strobe.
// assumes both ends run on the same clock.
`default_nettype none

interface ptcd_regbus_if;
    // write side: strobe, address, data, lanes, decode answer
    logic wr_en;
    logic [15:0] wr_addr;
    ptcd_pkg::ptcd_word_t wr_data;
    logic [3:0] wr_strb;
    logic wr_hit;
    // read side: strobe, address, data, decode answer
    logic rd_en;
    logic [15:0] rd_addr;
    ptcd_pkg::ptcd_word_t rd_data;
    logic rd_hit;

    modport front (
        output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
        input wr_hit, rd_data, rd_hit
    );
    modport regs (
        input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
        output wr_hit, rd_data, rd_hit
    );
endinterface

`default_nettype wire

// *** logic/ptcd_axil_slave.sv ***
// ptcd_axil_slave - AXI4-Lite slave front end, one write and one read at a time.
// assumes the master holds address and data valid until ready is seen.
`default_nettype none
`include "ptcd_defs.svh"

module ptcd_axil_slave (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // write address and data channels
    input wire logic [15:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    // write response channel
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    // read channels
    input wire logic [15:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    // register bank side
    ptcd_regbus_if.front bus
);
    logic wr_go;
    logic rd_go;

    // start only when idle, so a held valid is not taken twice
    assign wr_go = s_awvalid && s_wvalid && !s_awready && !s_bvalid;
    assign rd_go = s_arvalid && !s_arready && !s_rvalid;

    // the handshake cycle is the register access cycle
    assign bus.wr_en = s_awready;
    assign bus.wr_addr = s_awaddr;
    assign bus.wr_data = s_wdata;
    assign bus.wr_strb = s_wstrb;
    assign bus.rd_en = s_arready;
    assign bus.rd_addr = s_araddr;

    // write handshake and response
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_awready <= 1'b0;
            s_wready <= 1'b0;
            s_bvalid <= 1'b0;
            s_bresp <= `PTCD_RESP_OKAY;
        end else begin
            s_awready <= wr_go;
            s_wready <= wr_go;
            if (s_awready) begin
                s_bvalid <= 1'b1;
                s_bresp <= bus.wr_hit ? `PTCD_RESP_OKAY : `PTCD_RESP_DECERR;
            end else if (s_bready) begin
                s_bvalid <= 1'b0;
            end
        end
    end

    // read handshake and data
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_arready <= 1'b0;
            s_rvalid <= 1'b0;
            s_rdata <= `PTCD_RESET_WORD;
            s_rresp <= `PTCD_RESP_OKAY;
        end else begin
            s_arready <= rd_go;
            if (s_arready) begin
                s_rvalid <= 1'b1;
                s_rdata <= bus.rd_data;
                s_rresp <= bus.rd_hit ? `PTCD_RESP_OKAY : `PTCD_RESP_DECERR;
            end else if (s_rready) begin
                s_rvalid <= 1'b0;
            end
        end
    end
endmodule

`default_nettype wire

// *** logic/ptcd_dataset_regs.sv ***
// ptcd_dataset_regs - current and parent dataset snapshot registers of
// an ordinary timing node, read by software over AXI4-Lite.
// assumes the live dataset inputs come from logic on CLK_SYS.
// assumes software waits for done before trusting the words.
`default_nettype none
`include "ptcd_defs.svh"

module ptcd_dataset_regs (
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic RST_B,
    // AXI4-Lite write address and data
    input wire logic [15:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    // AXI4-Lite write response
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    // AXI4-Lite read
    input wire logic [15:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // live node state
    input wire logic IS_MASTER,
    input wire logic [63:0] OWN_IDENTITY,
    // live current dataset
    input wire logic [15:0] HOP_COUNT,
    input wire logic [63:0] MASTER_TIME_ERROR,
    input wire logic [63:0] PATH_LATENCY,
    // live parent dataset
    input wire logic [63:0] UPSTREAM_IDENTITY,
    input wire logic [15:0] UPSTREAM_PORT_NUMBER,
    input wire logic [7:0] ROOT_FIRST_PRIORITY,
    input wire logic [7:0] ROOT_SECOND_PRIORITY,
    input wire logic [63:0] ROOT_IDENTITY
);
    ptcd_regbus_if bus ();

    // current dataset snapshot state
    logic cur_req;
    logic cur_done;
    ptcd_pkg::ptcd_half_t hop_count;
    ptcd_pkg::ptcd_dword_t master_time_error;
    ptcd_pkg::ptcd_dword_t path_latency;

    // parent dataset snapshot state
    logic par_req;
    logic par_done;
    ptcd_pkg::ptcd_dword_t upstream_identity;
    ptcd_pkg::ptcd_half_t upstream_port_number;
    ptcd_pkg::ptcd_byte_t root_first_priority;
    ptcd_pkg::ptcd_byte_t root_second_priority;
    ptcd_pkg::ptcd_dword_t root_identity;

    // decoded write requests
    logic cur_req_wr;
    logic par_req_wr;

    // register read words
    ptcd_pkg::ptcd_word_t cur_ctrl_word;
    ptcd_pkg::ptcd_word_t par_ctrl_word;
    ptcd_pkg::ptcd_word_t prio_port_word;

    // current capture input, zero hops while master
    ptcd_pkg::ptcd_half_t next_hop_count;

    // parent capture inputs, own identity and port zero while master
    ptcd_pkg::ptcd_dword_t next_upstream_identity;
    ptcd_pkg::ptcd_half_t next_upstream_port_number;
    ptcd_pkg::ptcd_dword_t next_root_identity;

    // bus front end keeps every AXI output in a flip-flop
    ptcd_axil_slave u_front (
        .clk(CLK_SYS),
        .rst_b(RST_B),
        .s_awaddr(S_AXI_AWADDR),
        .s_awvalid(S_AXI_AWVALID),
        .s_awready(S_AXI_AWREADY),
        .s_wdata(S_AXI_WDATA),
        .s_wstrb(S_AXI_WSTRB),
        .s_wvalid(S_AXI_WVALID),
        .s_wready(S_AXI_WREADY),
        .s_bresp(S_AXI_BRESP),
        .s_bvalid(S_AXI_BVALID),
        .s_bready(S_AXI_BREADY),
        .s_araddr(S_AXI_ARADDR),
        .s_arvalid(S_AXI_ARVALID),
        .s_arready(S_AXI_ARREADY),
        .s_rdata(S_AXI_RDATA),
        .s_rresp(S_AXI_RRESP),
        .s_rvalid(S_AXI_RVALID),
        .s_rready(S_AXI_RREADY),
        .bus(bus.front)
    );

    // a request needs the top byte lane and a one in bit 30
    assign cur_req_wr = bus.wr_en
        && (bus.wr_addr == `PTCD_OFS_CUR_CTRL)
        && bus.wr_strb[`PTCD_REQ_LANE]
        && bus.wr_data[`PTCD_BIT_REQ];
    assign par_req_wr = bus.wr_en
        && (bus.wr_addr == `PTCD_OFS_PAR_CTRL)
        && bus.wr_strb[`PTCD_REQ_LANE]
        && bus.wr_data[`PTCD_BIT_REQ];

    // write decode: every mapped word answers, read-only ones ignore data
    always_comb begin
        case (bus.wr_addr)
            `PTCD_OFS_CUR_CTRL,
            `PTCD_OFS_HOP_COUNT,
            `PTCD_OFS_ERR_HIGH,
            `PTCD_OFS_ERR_LOW,
            `PTCD_OFS_LAT_HIGH,
            `PTCD_OFS_LAT_LOW,
            `PTCD_OFS_PAR_CTRL,
            `PTCD_OFS_UP_ID_LOW,
            `PTCD_OFS_UP_ID_HIGH,
            `PTCD_OFS_PRIO_PORT,
            `PTCD_OFS_ROOT_ID_LOW,
            `PTCD_OFS_ROOT_ID_HIGH: bus.wr_hit = 1'b1;
            default: bus.wr_hit = 1'b0;
        endcase
    end

    // current capture input: a master is zero hops from itself
    always_comb begin
        next_hop_count = HOP_COUNT;
        if (IS_MASTER) begin
            next_hop_count = `PTCD_RESET_HALF;
        end
    end

    // parent capture inputs: a master is its own parent and root
    always_comb begin
        next_upstream_identity = UPSTREAM_IDENTITY;
        next_upstream_port_number = UPSTREAM_PORT_NUMBER;
        next_root_identity = ROOT_IDENTITY;
        if (IS_MASTER) begin
            next_upstream_identity = OWN_IDENTITY;
            next_upstream_port_number = `PTCD_RESET_HALF;
            next_root_identity = OWN_IDENTITY;
        end
    end

    // current request lives one cycle; a write during it restarts it
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            cur_req <= 1'b0;
        end else begin
            cur_req <= cur_req_wr;
        end
    end

    // current done stays up until a fresh request withdraws it
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            cur_done <= 1'b0;
        end else if (cur_req_wr) begin
            cur_done <= 1'b0;
        end else if (cur_req) begin
            cur_done <= 1'b1;
        end
    end

    // hop count; every current word loads on the same edge
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            hop_count <= `PTCD_RESET_HALF;
        end else if (cur_req) begin
            hop_count <= next_hop_count;
        end
    end

    // master offset, both halves together so they match
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            master_time_error <= `PTCD_RESET_DWORD;
        end else if (cur_req) begin
            master_time_error <= MASTER_TIME_ERROR;
        end
    end

    // mean path latency, both halves together
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            path_latency <= `PTCD_RESET_DWORD;
        end else if (cur_req) begin
            path_latency <= PATH_LATENCY;
        end
    end

    // parent request: same one-cycle life as the current one
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            par_req <= 1'b0;
        end else begin
            par_req <= par_req_wr;
        end
    end

    // parent done: sticky, withdrawn only by a new request
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            par_done <= 1'b0;
        end else if (par_req_wr) begin
            par_done <= 1'b0;
        end else if (par_req) begin
            par_done <= 1'b1;
        end
    end

    // upstream identity; every parent word loads on the same edge
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            upstream_identity <= `PTCD_RESET_DWORD;
        end else if (par_req) begin
            upstream_identity <= next_upstream_identity;
        end
    end

    // upstream port number
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            upstream_port_number <= `PTCD_RESET_HALF;
        end else if (par_req) begin
            upstream_port_number <= next_upstream_port_number;
        end
    end

    // root identity
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            root_identity <= `PTCD_RESET_DWORD;
        end else if (par_req) begin
            root_identity <= next_root_identity;
        end
    end

    // root priorities are taken from the live inputs even as master
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            root_first_priority <= `PTCD_RESET_BYTE;
            root_second_priority <= `PTCD_RESET_BYTE;
        end else if (par_req) begin
            root_first_priority <= ROOT_FIRST_PRIORITY;
            root_second_priority <= ROOT_SECOND_PRIORITY;
        end
    end

    // current control word: only done and request bits, rest zero
    always_comb begin
        cur_ctrl_word = `PTCD_RESET_WORD;
        cur_ctrl_word[`PTCD_BIT_DONE] = cur_done;
        cur_ctrl_word[`PTCD_BIT_REQ] = cur_req;
    end

    // parent control word, same layout
    always_comb begin
        par_ctrl_word = `PTCD_RESET_WORD;
        par_ctrl_word[`PTCD_BIT_DONE] = par_done;
        par_ctrl_word[`PTCD_BIT_REQ] = par_req;
    end

    // priorities above, port number in the low half
    assign prio_port_word = {root_first_priority, root_second_priority,
        upstream_port_number};

    // read answer: mapped words hit, anything else is refused
    always_comb begin
        case (bus.rd_addr)
            `PTCD_OFS_CUR_CTRL,
            `PTCD_OFS_HOP_COUNT,
            `PTCD_OFS_ERR_HIGH,
            `PTCD_OFS_ERR_LOW,
            `PTCD_OFS_LAT_HIGH,
            `PTCD_OFS_LAT_LOW,
            `PTCD_OFS_PAR_CTRL,
            `PTCD_OFS_UP_ID_LOW,
            `PTCD_OFS_UP_ID_HIGH,
            `PTCD_OFS_PRIO_PORT,
            `PTCD_OFS_ROOT_ID_LOW,
            `PTCD_OFS_ROOT_ID_HIGH: bus.rd_hit = 1'b1;
            default: bus.rd_hit = 1'b0;
        endcase
    end

    // read data; software trusts these only after done is seen
    always_comb begin
        case (bus.rd_addr)
            `PTCD_OFS_CUR_CTRL: bus.rd_data = cur_ctrl_word;
            `PTCD_OFS_HOP_COUNT:
                bus.rd_data = {`PTCD_RESET_HALF, hop_count};
            `PTCD_OFS_ERR_HIGH:
                bus.rd_data = master_time_error[63:32];
            `PTCD_OFS_ERR_LOW:
                bus.rd_data = master_time_error[31:0];
            `PTCD_OFS_LAT_HIGH:
                bus.rd_data = path_latency[63:32];
            `PTCD_OFS_LAT_LOW:
                bus.rd_data = path_latency[31:0];
            `PTCD_OFS_PAR_CTRL: bus.rd_data = par_ctrl_word;
            `PTCD_OFS_UP_ID_LOW:
                bus.rd_data = upstream_identity[31:0];
            `PTCD_OFS_UP_ID_HIGH:
                bus.rd_data = upstream_identity[63:32];
            `PTCD_OFS_PRIO_PORT: bus.rd_data = prio_port_word;
            `PTCD_OFS_ROOT_ID_LOW:
                bus.rd_data = root_identity[31:0];
            `PTCD_OFS_ROOT_ID_HIGH:
                bus.rd_data = root_identity[63:32];
            default: begin
                // unmapped words read zero with a decode error
                bus.rd_data = `PTCD_RESET_WORD;
            end
        endcase
    end
endmodule

`default_nettype wire

// *** verif/ptcd_dataset_chk.sv ***
// ptcd_dataset_chk - bus timing and read-zero checks of the bank.
// assumes attachment by bind to ptcd_dataset_regs, one clock domain.
`default_nettype none
`include "ptcd_defs.svh"

module ptcd_dataset_chk (
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic RST_B,
    // write channels
    input wire logic S_AXI_AWREADY,
    input wire logic S_AXI_WREADY,
    input wire logic [1:0] S_AXI_BRESP,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    // read channels
    input wire logic [15:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic [1:0] S_AXI_RRESP,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY
);
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RST_B);

    // read taken at one address; answer lands one cycle later
    sequence s_rd(logic [15:0] a);
        S_AXI_ARREADY && S_AXI_ARADDR == a;
    endsequence

    a_aw_pulse: assert property (S_AXI_AWREADY |=> !S_AXI_AWREADY)
        else $error("write ready longer than one cycle");
    a_aw_w_pair: assert property (S_AXI_AWREADY == S_AXI_WREADY)
        else $error("address and data ready apart");
    a_b_after_aw: assert property (S_AXI_AWREADY |=> S_AXI_BVALID)
        else $error("write answer late");
    a_b_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
        S_AXI_BVALID && $stable(S_AXI_BRESP))
        else $error("write answer dropped early");
    a_r_after_ar: assert property (S_AXI_ARREADY |=> S_AXI_RVALID)
        else $error("read answer late");
    a_r_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
        S_AXI_RVALID && $stable(S_AXI_RDATA))
        else $error("read data changed before taken");
    a_ctrl_zero: assert property (s_rd(`PTCD_OFS_CUR_CTRL) or
        s_rd(`PTCD_OFS_PAR_CTRL) |=> S_AXI_RDATA[29:0] == 30'h0)
        else $error("control unused bits not zero");
    a_hop_upper: assert property (s_rd(`PTCD_OFS_HOP_COUNT) |=>
        S_AXI_RDATA[31:16] == 16'h0000)
        else $error("hop upper half not zero");
    a_unmapped: assert property (s_rd(16'h1318) |=>
        S_AXI_RRESP == `PTCD_RESP_DECERR && S_AXI_RDATA == 32'h0)
        else $error("unmapped read not refused");
endmodule

bind ptcd_dataset_regs ptcd_dataset_chk u_chk (
    .CLK_SYS(CLK_SYS), .RST_B(RST_B),
    .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WREADY(S_AXI_WREADY),
    .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID),
    .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARADDR(S_AXI_ARADDR),
    .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
    .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
    .S_AXI_RREADY(S_AXI_RREADY)
);

`default_nettype wire

// *** verif/test_ptp_current_parent_dataset_regs.sv ***
// test_ptp_current_parent_dataset_regs - self-checking bench of the
// dataset bank: reset values, refusals, snapshots, master override.
// assumes the bench is the only bus master and drives all live inputs.
`default_nettype none
`include "ptcd_defs.svh"

module test_ptp_current_parent_dataset_regs;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_b, aw_valid, aw_ready, w_valid, w_ready, b_valid;
    logic b_ready, ar_valid, ar_ready, r_valid, r_ready, is_master;
    logic [15:0] aw_addr, ar_addr, hop, up_port;
    logic [3:0] w_strb;
    logic [7:0] prio1, prio2;
    logic [63:0] own_id, err, lat, up_id, root_id;
    ptcd_pkg::ptcd_word_t w_data, r_data, ex [12];
    ptcd_pkg::ptcd_resp_t b_resp, r_resp, rs;
    int num_errors = 0;
    int cmp_count = 0;

    ptcd_dataset_regs DUT (
        .CLK_SYS(clk), .RST_B(rst_b),
        .S_AXI_AWADDR(aw_addr), .S_AXI_AWVALID(aw_valid),
        .S_AXI_AWREADY(aw_ready), .S_AXI_WDATA(w_data),
        .S_AXI_WSTRB(w_strb), .S_AXI_WVALID(w_valid),
        .S_AXI_WREADY(w_ready), .S_AXI_BRESP(b_resp),
        .S_AXI_BVALID(b_valid), .S_AXI_BREADY(b_ready),
        .S_AXI_ARADDR(ar_addr), .S_AXI_ARVALID(ar_valid),
        .S_AXI_ARREADY(ar_ready), .S_AXI_RDATA(r_data),
        .S_AXI_RRESP(r_resp), .S_AXI_RVALID(r_valid),
        .S_AXI_RREADY(r_ready), .IS_MASTER(is_master),
        .OWN_IDENTITY(own_id), .HOP_COUNT(hop),
        .MASTER_TIME_ERROR(err), .PATH_LATENCY(lat),
        .UPSTREAM_IDENTITY(up_id), .UPSTREAM_PORT_NUMBER(up_port),
        .ROOT_FIRST_PRIORITY(prio1), .ROOT_SECOND_PRIORITY(prio2),
        .ROOT_IDENTITY(root_id)
    );

    // 250 MHz system clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic complete_run();
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk_word(input string nm, input ptcd_pkg::ptcd_word_t e,
                            input ptcd_pkg::ptcd_word_t g);
        cmp_count++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            num_errors++;
        end
    endtask

    task automatic chk_resp(input string nm, input ptcd_pkg::ptcd_resp_t e,
                            input ptcd_pkg::ptcd_resp_t g);
        cmp_count++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            num_errors++;
        end
    endtask

    // handshake flags seen at the last edge, picked by number
    function automatic logic hs(input int k);
        logic [3:0] v;
        v = {r_valid, ar_ready, b_valid, aw_ready};
        return v[k];
    endfunction

    // bounded wait; a hang ends the run as a failure
    task automatic wait_hs(input int k);
        int n;
        for (n = 0; n < 20 && hs(k) !== 1'b1; n++) begin
            @(posedge clk);
        end
        if (hs(k) !== 1'b1) begin
            $display("[ERR] handshake %0d expected 1 seen %b", k, hs(k));
            num_errors++;
            complete_run();
        end
    endtask

    task automatic bus_wr(input logic [15:0] a, input ptcd_pkg::ptcd_word_t d,
                          input logic [3:0] s);
        @(posedge clk);
        aw_addr <= a;
        w_data <= d;
        w_strb <= s;
        aw_valid <= 1'b1;
        w_valid <= 1'b1;
        @(posedge clk);
        wait_hs(0);
        aw_valid <= 1'b0;
        w_valid <= 1'b0;
        // answer held back a few cycles at random
        repeat ($urandom % 3) @(posedge clk);
        b_ready <= 1'b1;
        @(posedge clk);
        wait_hs(1);
        rs = b_resp;
        b_ready <= 1'b0;
    endtask

    task automatic bus_rd(input logic [15:0] a,
                          output ptcd_pkg::ptcd_word_t d);
        @(posedge clk);
        ar_addr <= a;
        ar_valid <= 1'b1;
        @(posedge clk);
        wait_hs(2);
        ar_valid <= 1'b0;
        // data held back a few cycles at random
        repeat ($urandom % 3) @(posedge clk);
        r_ready <= 1'b1;
        @(posedge clk);
        wait_hs(3);
        d = r_data;
        rs = r_resp;
        r_ready <= 1'b0;
    endtask

    task automatic rd_chk(input logic [15:0] a, input ptcd_pkg::ptcd_word_t e,
                          input ptcd_pkg::ptcd_resp_t er);
        ptcd_pkg::ptcd_word_t d;
        bus_rd(a, d);
        chk_word($sformatf("word %h", a), e, d);
        chk_resp($sformatf("rresp %h", a), er, rs);
    endtask

    // request, then poll done a bounded number of times
    task automatic snap(input logic [15:0] c);
        ptcd_pkg::ptcd_word_t d;
        int n;
        bus_wr(c, 32'h4000_0000, 4'hf);
        d = 32'h0;
        for (n = 0; n < 10 && d[31] !== 1'b1; n++) begin
            bus_rd(c, d);
        end
        chk_word("control after snapshot", 32'h8000_0000, d);
    endtask

    task automatic live(input logic m);
        @(posedge clk);
        is_master <= m;
        own_id <= {$urandom, $urandom};
        hop <= 16'($urandom);
        err <= {$urandom, $urandom};
        lat <= {$urandom, $urandom};
        up_id <= {$urandom, $urandom};
        up_port <= 16'($urandom);
        prio1 <= 8'($urandom);
        prio2 <= 8'($urandom);
        root_id <= {$urandom, $urandom};
    endtask

    function automatic logic [15:0] adr(input int j);
        return (j < 6 ? 16'h1300 : 16'h1400) + 16'(4 * (j % 6));
    endfunction

    // expected word at a snapshot of the present live inputs
    function automatic ptcd_pkg::ptcd_word_t exp_reg(input int j);
        logic [63:0] u;
        logic [63:0] r;
        u = is_master ? own_id : up_id;
        r = is_master ? own_id : root_id;
        case (j % 6)
            0: return 32'h8000_0000;
            1: return j < 6 ? {16'h0000, is_master ? 16'h0000 : hop} : u[31:0];
            2: return j < 6 ? err[63:32] : u[63:32];
            3: return j < 6 ? err[31:0] :
                {prio1, prio2, is_master ? 16'h0000 : up_port};
            4: return j < 6 ? lat[63:32] : r[31:0];
            default: return j < 6 ? lat[31:0] : r[63:32];
        endcase
    endfunction

    initial begin
        {aw_valid, w_valid, b_ready, ar_valid, r_ready} = 5'h0;
        {aw_addr, ar_addr, w_data, w_strb} = '0;
        {is_master, own_id, hop, err, lat, up_id, up_port} = '0;
        {prio1, prio2, root_id} = '0;
        rst_b = 1'b0;
        void'($urandom(79194));
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        live(1'b0);
        // every word zero out of reset, live inputs not yet captured
        for (int j = 0; j < 12; j++) begin
            rd_chk(adr(j), 32'h0, `PTCD_RESP_OKAY);
        end
        // refused or ignored writes leave both control words and the error high word at zero
        rd_chk(16'h1318, 32'h0, `PTCD_RESP_DECERR);
        bus_wr(16'h1318, 32'hffff_ffff, 4'hf);
        chk_resp("unmapped bresp", `PTCD_RESP_DECERR, rs);
        bus_wr(`PTCD_OFS_CUR_CTRL, 32'h4000_0000, 4'h7);
        bus_wr(`PTCD_OFS_PAR_CTRL, 32'hbfff_ffff, 4'hf);
        bus_wr(`PTCD_OFS_ERR_HIGH, 32'hffff_ffff, 4'hf);
        chk_resp("read-only bresp", `PTCD_RESP_OKAY, rs);
        rd_chk(`PTCD_OFS_CUR_CTRL, 32'h0, `PTCD_RESP_OKAY);
        rd_chk(`PTCD_OFS_PAR_CTRL, 32'h0, `PTCD_RESP_OKAY);
        rd_chk(`PTCD_OFS_ERR_HIGH, 32'h0, `PTCD_RESP_OKAY);
        // slave and master rounds; live inputs move before readback
        for (int t = 0; t < 6; t++) begin
            live(t[0]);
            snap(`PTCD_OFS_CUR_CTRL);
            snap(`PTCD_OFS_PAR_CTRL);
            for (int j = 0; j < 12; j++) begin
                ex[j] = exp_reg(j);
            end
            live(~t[0]);
            for (int j = 0; j < 12; j++) begin
                rd_chk(adr(j), ex[j], `PTCD_RESP_OKAY);
            end
        end
        complete_run();
    end
endmodule

`default_nettype wire
